/* rtl/dcg_pkg.sv */
// What this block does
// - doze only while doze_enable bit 11 set
// - ratio field bits 14:12, reset 1:1
// - peripherals stay full rate during doze
// - doze leaves system clock source, rate untouched
// - slowed core clock stays synchronous to peripherals
// - return_on_interrupt bit 15: interrupt restores speed
// - return_on_interrupt clear: interrupts leave doze alone
// - disable bit stops all module clocks
// - disabled module registers ignore writes, reads invalid
// - module enabled only if clear and implemented
// - implemented modules reset with disable bit clear
// - setting disable stops module at next core tick, one cycle later at full rate
// - clearing disable restarts module at next core tick, one cycle later at full rate
package dcg_pkg;
   localparam int DCG_NUM_PERIPH = 8;
   localparam int DCG_CODE_W = 3;
   localparam int DCG_CNT_W = 7;
   // which peripherals exist in this variant
   localparam logic [7:0] DCG_IMPL_MASK = 8'hFF;
   // register byte offsets
   localparam logic [7:0] DCG_OFS_CLOCK_DIVIDER = 8'h00;
   localparam logic [7:0] DCG_OFS_PERIPH_GATE = 8'h04;
   localparam logic [7:0] DCG_OFS_STATUS = 8'h08;
   // clock_divider_register fields
   localparam int DCG_BIT_RETURN_ON_INTERRUPT = 15;
   localparam int DCG_BIT_RATIO_HI = 14;
   localparam int DCG_BIT_RATIO_LO = 12;
   localparam int DCG_BIT_DOZE_ENABLE = 11;
   // status register fields
   localparam int DCG_BIT_STAT_DOZE = 0;
   localparam int DCG_BIT_STAT_CODE_LO = 1;
   localparam int DCG_BIT_STAT_EN_LO = 8;
   // reset values
   localparam logic DCG_RST_DOZE_ENABLE = 1'b0;
   localparam logic DCG_RST_RETURN_ON_INTERRUPT = 1'b0;
   localparam logic [2:0] DCG_RST_RATIO = 3'h0;
   localparam logic [7:0] DCG_RST_PERIPH_GATE = 8'h00;
   localparam logic [6:0] DCG_RST_CNT = 7'h00;
   localparam logic [31:0] DCG_RST_RDATA = 32'h0000_0000;
   typedef enum logic [1:0] {
      DCG_ST_FULL = 2'b01,
      DCG_ST_DOZE = 2'b10
   } dcg_state_t;
   // divisor 2**code, counter wraps at divisor-1
   function automatic logic [6:0] dcg_div_limit(input logic [2:0] code);
      logic [7:0] div;
      div = 8'h01 << code;
      return 7'(div - 8'h01);
   endfunction
endpackage

/* rtl/dcg_core_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module dcg_core_divider
   import dcg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [2:0] i_code,
   output logic o_tick,
   output logic [2:0] o_code
);
   typedef struct packed {
      logic [6:0] cnt;
      logic [2:0] code;
   } dcg_div_t;
   dcg_div_t st;
   dcg_div_t next_st;
   logic tick;

   assign tick = (st.cnt == dcg_div_limit(st.code));
   always_comb begin
      next_st = st;
      if (tick) begin
         next_st.cnt = DCG_RST_CNT;
         next_st.code = i_code;
      end else begin
         next_st.cnt = 7'(st.cnt + 7'h01);
      end
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st <= '{cnt: DCG_RST_CNT, code: DCG_RST_RATIO};
      end else begin
         st <= next_st;
      end
   end
   assign o_tick = tick;
   assign o_code = st.code;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_DIV_BY_FOUR: assert property (tick && i_code == 3'h2 |=> !tick [*3] ##1 tick)
      else $error("divide by four spacing wrong");
   AST_CODE_AT_TICK: assert property (!$past(tick) |-> $stable(st.code))
      else $error("ratio changed between core ticks");
endmodule
`default_nettype wire

/* rtl/dcg_gate_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module dcg_gate_sync
   import dcg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_tick,
   input wire logic [7:0] i_request,
   output logic [7:0] o_enable
);
   typedef struct packed {
      logic [7:0] en;
   } dcg_gate_t;
   dcg_gate_t st;
   dcg_gate_t next_st;

   always_comb begin
      next_st = st;
      if (i_tick) begin
         next_st.en = i_request & DCG_IMPL_MASK;
      end
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st.en <= DCG_IMPL_MASK;
      end else begin
         st <= next_st;
      end
   end
   assign o_enable = st.en;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_GATE_AT_BOUNDARY: assert property ($changed(o_enable) |-> $past(i_tick))
      else $error("gate changed off a core boundary");
   AST_GATE_FOLLOWS: assert property (i_tick |=> o_enable == $past(i_request & DCG_IMPL_MASK))
      else $error("gate did not follow request");
endmodule
`default_nettype wire

/* rtl/dcg_clock_gating.sv */
`timescale 1ns/10ps
`default_nettype none
module dcg_clock_gating
   import dcg_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_NRST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_IRQ,
   output logic O_CORE_CE,
   output logic O_SYS_CE,
   output logic [7:0] O_PERIPH_CLK_EN,
   output logic [7:0] O_PERIPH_REG_EN
);
   typedef struct packed {
      dcg_state_t state;
      logic doze_enable;
      logic return_on_interrupt;
      logic [2:0] ratio;
      logic [7:0] peripheral_clock_gate;
      logic [31:0] rdata;
      logic slverr;
   } dcg_top_t;
   dcg_top_t st;
   dcg_top_t next_st;

   logic core_tick;
   logic [2:0] applied_code;
   logic [2:0] req_code;
   logic [7:0] periph_en;
   logic setup;
   logic access;
   logic wr_div;
   logic wr_gate;
   logic mapped;

   assign setup = I_PSEL && !I_PENABLE;
   assign access = I_PSEL && I_PENABLE;
   assign mapped = (I_PADDR == DCG_OFS_CLOCK_DIVIDER) || (I_PADDR == DCG_OFS_PERIPH_GATE)
      || (I_PADDR == DCG_OFS_STATUS);
   assign wr_div = access && I_PWRITE && (I_PADDR == DCG_OFS_CLOCK_DIVIDER);
   assign wr_gate = access && I_PWRITE && (I_PADDR == DCG_OFS_PERIPH_GATE);

   // ratio reaches the core divider only while doze is on
   assign req_code = st.doze_enable ? st.ratio : DCG_RST_RATIO;

   dcg_core_divider u_div (
      .i_clk(I_MCLK),
      .i_nrst(I_NRST),
      .i_code(req_code),
      .o_tick(core_tick),
      .o_code(applied_code)
   );

   dcg_gate_sync u_gate (
      .i_clk(I_MCLK),
      .i_nrst(I_NRST),
      .i_tick(core_tick),
      .i_request(~st.peripheral_clock_gate),
      .o_enable(periph_en)
   );

   function automatic logic [31:0] read_word(input logic [7:0] addr, input dcg_top_t s,
      input logic [2:0] code, input logic [7:0] en);
      logic [31:0] w;
      w = DCG_RST_RDATA;
      unique case (addr)
         DCG_OFS_CLOCK_DIVIDER: begin
            w[DCG_BIT_RETURN_ON_INTERRUPT] = s.return_on_interrupt;
            w[DCG_BIT_RATIO_HI:DCG_BIT_RATIO_LO] = s.ratio;
            w[DCG_BIT_DOZE_ENABLE] = s.doze_enable;
         end
         DCG_OFS_PERIPH_GATE: begin
            w[7:0] = s.peripheral_clock_gate;
         end
         DCG_OFS_STATUS: begin
            w[DCG_BIT_STAT_DOZE] = (s.state == DCG_ST_DOZE);
            w[DCG_BIT_STAT_CODE_LO +: 3] = code;
            w[DCG_BIT_STAT_EN_LO +: 8] = en;
         end
         default: begin
            w = DCG_RST_RDATA;
         end
      endcase
      return w;
   endfunction

   always_comb begin
      next_st = st;
      // read data and error flag are prepared in the setup cycle
      if (setup) begin
         next_st.rdata = read_word(I_PADDR, st, applied_code, periph_en);
         next_st.slverr = !mapped;
      end
      if (wr_div) begin
         next_st.return_on_interrupt = I_PWDATA[DCG_BIT_RETURN_ON_INTERRUPT];
         next_st.ratio = I_PWDATA[DCG_BIT_RATIO_HI:DCG_BIT_RATIO_LO];
         next_st.doze_enable = I_PWDATA[DCG_BIT_DOZE_ENABLE];
      end
      if (wr_gate) begin
         next_st.peripheral_clock_gate = I_PWDATA[7:0];
      end
      // interrupt return; without the bit interrupts are ignored
      if (I_IRQ && st.return_on_interrupt && st.doze_enable) begin
         next_st.doze_enable = 1'b0;
      end
      // mode follows the request only at a core boundary
      if (core_tick) begin
         unique case (st.state)
            DCG_ST_FULL: begin
               if (st.doze_enable) begin
                  next_st.state = DCG_ST_DOZE;
               end
            end
            DCG_ST_DOZE: begin
               if (!st.doze_enable) begin
                  next_st.state = DCG_ST_FULL;
               end
            end
            default: begin
               next_st.state = DCG_ST_FULL;
            end
         endcase
      end
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         st.state <= DCG_ST_FULL;
         st.doze_enable <= DCG_RST_DOZE_ENABLE;
         st.return_on_interrupt <= DCG_RST_RETURN_ON_INTERRUPT;
         st.ratio <= DCG_RST_RATIO;
         st.peripheral_clock_gate <= DCG_RST_PERIPH_GATE;
         st.rdata <= DCG_RST_RDATA;
         st.slverr <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign O_PREADY = 1'b1;
   assign O_PRDATA = st.rdata;
   assign O_PSLVERR = access && st.slverr;
   assign O_CORE_CE = core_tick;
   // system and peripheral rate never depends on doze
   assign O_SYS_CE = 1'b1;
   assign O_PERIPH_CLK_EN = periph_en;
   assign O_PERIPH_REG_EN = periph_en;

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_NRST);

   AST_FULL_RATE_WHEN_OFF: assert property (
      !st.doze_enable && core_tick |=> applied_code == 3'h0)
      else $error("core slowed without doze enable");
   AST_DOZE_TRACKS_ENABLE: assert property (
      core_tick |=> (st.state == DCG_ST_DOZE) == $past(st.doze_enable))
      else $error("doze state off its enable");
   AST_RATIO_APPLIED: assert property (
      core_tick && st.doze_enable |=> applied_code == $past(st.ratio))
      else $error("ratio not applied at boundary");
   AST_PERIPH_UNTOUCHED: assert property (
      $changed(O_PERIPH_CLK_EN)
      |-> $past(O_PERIPH_CLK_EN != (~st.peripheral_clock_gate & DCG_IMPL_MASK)))
      else $error("doze changed peripheral clocks");
   AST_SYS_FULL: assert property (O_SYS_CE)
      else $error("system rate changed");
   AST_IRQ_RETURN: assert property (
      I_IRQ && st.return_on_interrupt && st.doze_enable |=> !st.doze_enable)
      else $error("interrupt did not end doze");
   AST_IRQ_NO_RETURN_HOLD: assert property (
      I_IRQ && !st.return_on_interrupt && st.doze_enable && !wr_div
      |=> st.doze_enable && $stable(st.ratio))
      else $error("interrupt changed doze without return bit");
   AST_DISABLED_STOPPED: assert property (
      core_tick && st.peripheral_clock_gate[0] |=> !O_PERIPH_CLK_EN[0])
      else $error("disabled module still clocked");
   AST_REG_BLOCKED: assert property (
      core_tick |=> O_PERIPH_REG_EN == $past(~st.peripheral_clock_gate & DCG_IMPL_MASK))
      else $error("register access left open");
   AST_IMPL_ONLY: assert property ((O_PERIPH_CLK_EN & ~DCG_IMPL_MASK) == 8'h00)
      else $error("unimplemented module enabled");
   AST_DISABLE_ONE_CYCLE: assert property (
      wr_gate && I_PWDATA[0] && st.state == DCG_ST_FULL && !st.doze_enable
      |=> ##1 !O_PERIPH_CLK_EN[0])
      else $error("disable not applied one cycle later");
   AST_ENABLE_ONE_CYCLE: assert property (
      wr_gate && !I_PWDATA[0] && st.state == DCG_ST_FULL && !st.doze_enable
      |=> ##1 O_PERIPH_CLK_EN[0] == DCG_IMPL_MASK[0])
      else $error("enable not applied one cycle later");
   AST_STATE_AT_TICK: assert property ($changed(st.state) |-> $past(core_tick))
      else $error("mode changed off boundary");

   COV_DOZE_128: cover property (st.state == DCG_ST_DOZE && applied_code == 3'h7);
   COV_IRQ_EXIT: cover property (I_IRQ && st.return_on_interrupt && st.doze_enable);
   COV_GATE_OFF: cover property ($fell(O_PERIPH_CLK_EN[0]));
   COV_UNMAPPED: cover property (O_PSLVERR);
endmodule
`default_nettype wire

/* dv/dcg_clock_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module dcg_clock_sink (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_core_ce,
   input wire logic [7:0] i_periph_en,
   output logic [15:0] o_core_cnt,
   output logic [15:0] o_per_cnt
);
   // counts core clock enables and clocks seen by module 0
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_core_cnt <= 16'h0000;
         o_per_cnt <= 16'h0000;
      end else begin
         if (i_core_ce) begin
            o_core_cnt <= o_core_cnt + 16'h0001;
         end
         if (i_periph_en[0]) begin
            o_per_cnt <= o_per_cnt + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/test_doze_and_peripheral_clock_gating.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_doze_and_peripheral_clock_gating;
   import dcg_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, irq = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, core_ce, sys_ce, err;
   logic [7:0] pclk_en, preg_en;
   logic [15:0] core_cnt, per_cnt, c0, p0;
   int fail_count = 0, tests_run = 0, cyc = 0, n;
   always #12.5 clk = ~clk;
   dcg_clock_gating dut (.I_MCLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_IRQ(irq), .O_CORE_CE(core_ce),
      .O_SYS_CE(sys_ce), .O_PERIPH_CLK_EN(pclk_en), .O_PERIPH_REG_EN(preg_en));
   dcg_clock_sink sink (.i_clk(clk), .i_nrst(nrst), .i_core_ce(core_ce),
      .i_periph_en(pclk_en), .o_core_cnt(core_cnt), .o_per_cnt(per_cnt));
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // cycles between two core ticks
   task automatic period(output int m);
      int k;
      k = 0;
      while (core_ce !== 1'b1 && k < 300) begin
         @(posedge clk);
         k++;
      end
      @(posedge clk);
      m = 1;
      while (core_ce !== 1'b1 && m < 300) begin
         @(posedge clk);
         m++;
      end
   endtask
   task automatic t_reset;
      apb(1'b0, DCG_OFS_CLOCK_DIVIDER, 32'h0);
      `CHK("divider", 32'h0000_0000, rd)
      `CHK("mapped err", 1'b0, err)
      `CHK("pready", 1'b1, pready)
      apb(1'b0, DCG_OFS_PERIPH_GATE, 32'h0);
      `CHK("gate", 32'h0000_0000, rd)
      `CHK("clk_en", DCG_IMPL_MASK, pclk_en)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      period(n);
      `CHK("reset period", 1, n)
      $display("test reset done");
   endtask
   task automatic t_ratio;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, DCG_OFS_CLOCK_DIVIDER, {17'h0, 3'(c), 12'h800});
         period(n);
         period(n);
         `CHK("period", 1 << c, n)
         apb(1'b0, DCG_OFS_STATUS, 32'h0);
         `CHK("status", {16'h0, 8'hFF, 4'h0, 3'(c), 1'b1}, rd)
         `CHK("sys_ce", 1'b1, sys_ce)
      end
      apb(1'b1, DCG_OFS_CLOCK_DIVIDER, 32'h0000_3800);
      period(n);
      c0 = core_cnt;
      p0 = per_cnt;
      repeat (64) @(posedge clk);
      `CHK("core ticks", 16'h0008, 16'(core_cnt - c0))
      `CHK("periph ticks", 16'h0040, 16'(per_cnt - p0))
      apb(1'b1, DCG_OFS_CLOCK_DIVIDER, 32'h0000_7000);
      period(n);
      period(n);
      `CHK("no doze period", 1, n)
      $display("test ratio done");
   endtask
   task automatic t_irq;
      for (int r = 0; r < 2; r++) begin
         apb(1'b1, DCG_OFS_CLOCK_DIVIDER, r ? 32'h0000_A800 : 32'h0000_2800);
         irq <= 1'b1;
         @(posedge clk);
         irq <= 1'b0;
         @(posedge clk);
         apb(1'b0, DCG_OFS_CLOCK_DIVIDER, 32'h0);
         `CHK("irq divider", r ? 32'h0000_A000 : 32'h0000_2800, rd)
         period(n);
         period(n);
         `CHK("irq period", r ? 1 : 4, n)
      end
      $display("test irq done");
   endtask
   task automatic t_gate;
      for (int b = 0; b < 8; b += 7) begin
         apb(1'b1, DCG_OFS_PERIPH_GATE, 32'(1 << b));
         `CHK("clk_en held", 8'hFF, pclk_en)
         @(posedge clk);
         #1;
         `CHK("clk_en off", ~8'(1 << b), pclk_en)
         `CHK("reg_en off", ~8'(1 << b), preg_en)
         @(posedge clk);
         apb(1'b1, DCG_OFS_PERIPH_GATE, 32'h0);
         `CHK("clk_en held on", ~8'(1 << b), pclk_en)
         @(posedge clk);
         #1;
         `CHK("clk_en on", 8'hFF, pclk_en)
         @(posedge clk);
      end
      apb(1'b1, DCG_OFS_CLOCK_DIVIDER, 32'h0000_3800);
      period(n);
      apb(1'b1, DCG_OFS_PERIPH_GATE, 32'h0000_0002);
      n = 0;
      while (pclk_en === 8'hFF && n < 20) begin
         @(posedge clk);
         n++;
      end
      `CHK("doze gate delay", 1'b1, n <= 10)
      `CHK("doze gate", 8'hFD, pclk_en)
      $display("test gate done");
   endtask
   // reset in mid-run while dozing with a module gated
   task automatic t_midreset;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("reset clk_en mid", DCG_IMPL_MASK, pclk_en)
      nrst <= 1'b1;
      @(posedge clk);
      apb(1'b0, DCG_OFS_CLOCK_DIVIDER, 32'h0);
      `CHK("reset divider mid", 32'h0000_0000, rd)
      period(n);
      `CHK("reset period mid", 1, n)
      $display("test midreset done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_ratio();
      t_irq();
      t_gate();
      t_midreset();
      give_verdict();
   end
endmodule
`default_nettype wire
